// ---- inc/status_flags_pkg.sv ----
/*
 * Constants for the primary status flag register block: offset, reset value,
 * bit positions, queue sizes and fuse refresh timing.
 * Assumes a 50 MHz device clock and a register port with an 8-bit address.
 */
package status_flags_pkg;

   // ==========================================================================
   // Register map
   localparam logic [7:0] STATUS_OFFSET = 8'h11;
   localparam logic [7:0] STATUS_RESET = 8'h80;

   // ==========================================================================
   // Bit positions inside the status byte
   localparam int BIT_BUSY = 7;
   localparam int BIT_DONE = 6;
   localparam int BIT_WERR = 5;
   localparam int BIT_READY = 4;
   localparam int BIT_LEVEL = 3;
   localparam int BIT_OVERRUN = 2;
   localparam int BIT_FULL = 1;
   localparam int BIT_PARITY = 0;

   // ==========================================================================
   // Queue geometry
   localparam int QUEUE_DEPTH = 320;
   localparam int QUEUE_DEPTH_THREE_CH = 318;
   localparam int COUNT_W = 9;

   // ==========================================================================
   // Fuse refresh timing
   localparam int CLOCK_HZ = 50000000;
   localparam int REFRESH_TIME_US = 2200;
   localparam int REFRESH_CYCLES = (CLOCK_HZ / 1000000) * REFRESH_TIME_US;

   // ==========================================================================
   // Queue modes and refresh states
   typedef enum logic [1:0] {
      QMODE_BYPASS = 2'h0,
      QMODE_NORMAL = 2'h1,
      QMODE_STREAM = 2'h2,
      QMODE_TRIGGER = 2'h3
   } queue_mode_t;

   typedef enum logic [1:0] {
      REFRESH_RUN = 2'h0,
      REFRESH_IDLE = 2'h1
   } refresh_state_t;

endpackage : status_flags_pkg

// ---- design/status_flag_cell.sv ----
/*
 * One clear-on-read sticky flag.
 * Assumes set and clear are single-cycle pulses from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module status_flag_cell (
   input wire logic i_clock, // Device clock.
   input wire logic i_rst, // Synchronous reset, active high.
   input wire logic i_set, // Event that sets the flag.
   input wire logic i_clear, // Clearing request.
   output logic o_flag // Sticky flag value.
);

   logic next_flag;

   // The set term wins over a coincident clear so no event is lost.
   always_comb begin
      next_flag = i_set | (o_flag & ~i_clear);
   end

   // Flag register.
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_flag <= 1'b0;
      end else begin
         o_flag <= next_flag;
      end
   end

endmodule // status_flag_cell

`default_nettype wire

// ---- design/status_flags_clear_on_read.sv ----
/*
 * Primary status flag register: fuse refresh busy and done, write error,
 * queue flags and latched parity fault, with clear on read.
 * Assumes register strobes and queue events come from logic on i_clock;
 * chip select arrives from a pin and is synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none

module status_flags_clear_on_read
   import status_flags_pkg::*;
#(
   parameter int REFRESH_COUNT = REFRESH_CYCLES, // Refresh length in clocks.
   parameter int COUNT_WIDTH = COUNT_W // Width of the queue sample count.
) (
   input wire logic i_clock, // Device clock, 50 MHz.
   input wire logic i_rst, // Power-on or soft reset, synchronous, active high.
   input wire logic i_reg_read, // Register read strobe, one cycle.
   input wire logic i_reg_write, // Register write strobe, one cycle.
   input wire logic [7:0] i_reg_addr, // Register address.
   input wire logic i_cs_n, // Serial chip select pin, active low.
   input wire logic i_queue_read_spi, // Queue data read over the serial port.
   input wire logic i_sample_write, // Sample written into the queue, pulse.
   input wire logic i_sample_overwrite, // Write overwrote old data, pulse.
   input wire logic [COUNT_WIDTH-1:0] i_sample_count, // Samples held after update.
   input wire logic [COUNT_WIDTH-1:0] i_level_threshold, // Programmed threshold.
   input wire logic [1:0] i_queue_mode, // Queue mode, see queue_mode_t.
   input wire logic i_three_channels, // Exactly three channels enabled.
   input wire logic i_parity_event, // Parity error event level.
   input wire logic i_parity_live, // Live parity error status.
   input wire logic i_latch_source_select, // 1: edge of event, 0: live status.
   output logic [7:0] o_read_data, // Status byte, registered.
   output logic o_read_valid, // Read data valid, one cycle.
   output logic o_interrupt_pin_zero, // Busy view on interrupt pin zero.
   output logic o_write_alarm, // Pulse on a write during refresh.
   output logic o_level_event, // Level-reached flag for interrupt routing.
   output logic o_realign_read_ptr, // Move read pointer to first axis.
   output logic o_first_axis_next // Next queue read must be a first-axis word.
);

   // =========================================================================
   // Refresh sequencing
   refresh_state_t state, next_state;
   logic [31:0] refresh_cnt, next_refresh_cnt;
   logic refresh_end;

   // Counts the refresh after every reset, then rests in idle.
   always_comb begin
      next_state = state;
      next_refresh_cnt = refresh_cnt;
      refresh_end = 1'b0;
      unique case (state)
         REFRESH_RUN: begin
            if (refresh_cnt >= 32'(REFRESH_COUNT - 1)) begin
               next_state = REFRESH_IDLE;
               refresh_end = 1'b1;
            end else begin
               next_refresh_cnt = refresh_cnt + 32'h1;
            end
         end
         REFRESH_IDLE: begin
            next_state = REFRESH_IDLE;
         end
         default: begin
            next_state = REFRESH_RUN; // An illegal code returns to refresh run and keeps the count.
         end
      endcase
   end

   // Refresh state registers.
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         state <= REFRESH_RUN;
         refresh_cnt <= 32'h0;
      end else begin
         state <= next_state;
         refresh_cnt <= next_refresh_cnt;
      end
   end

   logic busy;
   assign busy = (state == REFRESH_RUN);

   // =========================================================================
   // Chip select synchroniser and clearing of the level flag
   logic cs_meta, cs_sync, cs_sync_d;
   logic next_cs_meta, next_cs_sync, next_cs_sync_d;
   logic level_clear_pending, next_level_clear_pending;
   logic status_read, cs_rise;

   assign status_read = i_reg_read & (i_reg_addr == STATUS_OFFSET);
   assign cs_rise = cs_sync & ~cs_sync_d;

   // Chip select is a pin, so it passes two flops before any use.
   always_comb begin
      next_cs_meta = i_cs_n;
      next_cs_sync = cs_meta;
      next_cs_sync_d = cs_sync;
      // A status read during a serial queue read or while chip select is low waits for chip select release.
      if (status_read & (i_queue_read_spi | ~cs_sync)) begin
         next_level_clear_pending = 1'b1;
      end else if (cs_rise) begin
         next_level_clear_pending = 1'b0;
      end else begin
         next_level_clear_pending = level_clear_pending;
      end
   end

   // Synchroniser and pending-clear registers.
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         cs_meta <= 1'b1;
         cs_sync <= 1'b1;
         cs_sync_d <= 1'b1;
         level_clear_pending <= 1'b0;
      end else begin
         cs_meta <= next_cs_meta;
         cs_sync <= next_cs_sync;
         cs_sync_d <= next_cs_sync_d;
         level_clear_pending <= next_level_clear_pending;
      end
   end

   // =========================================================================
   // Event detection
   logic parity_event_d, next_parity_event_d;
   logic level_set, overrun_set, parity_set, werr_set, level_clear;
   logic full_now;

   // Full depth depends on whether three channels are enabled.
   function automatic logic is_full(input logic [COUNT_WIDTH-1:0] cnt,
                                    input logic three);
      if (three) begin
         is_full = (cnt >= COUNT_WIDTH'(QUEUE_DEPTH_THREE_CH));
      end else begin
         is_full = (cnt >= COUNT_WIDTH'(QUEUE_DEPTH));
      end
   endfunction

   // Derives set terms for write error, level, overrun and parity, the level clear term and full_now.
   always_comb begin
      next_parity_event_d = i_parity_event;
      werr_set = i_reg_write & busy;
      level_set = i_sample_write & (i_sample_count > i_level_threshold);
      overrun_set = i_sample_overwrite &
                    ((i_queue_mode == QMODE_STREAM) | (i_queue_mode == QMODE_TRIGGER));
      if (i_latch_source_select) begin
         parity_set = i_parity_event & ~parity_event_d;
      end else begin
         parity_set = i_parity_live;
      end
      // Level flag clears at once unless a serial queue read or a low chip select holds it.
      level_clear = (status_read & ~(i_queue_read_spi | ~cs_sync))
                    | (level_clear_pending & cs_rise);
      full_now = is_full(i_sample_count, i_three_channels);
   end

   // Parity edge detector register.
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         parity_event_d <= 1'b0;
      end else begin
         parity_event_d <= next_parity_event_d;
      end
   end

   // =========================================================================
   // Sticky flags
   logic done_flag, werr_flag, level_flag, overrun_flag, full_flag, parity_flag;

   status_flag_cell u_done (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_set(refresh_end),
      .i_clear(status_read),
      .o_flag(done_flag)
   );

   status_flag_cell u_werr (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_set(werr_set),
      .i_clear(status_read),
      .o_flag(werr_flag)
   );

   status_flag_cell u_level (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_set(level_set),
      .i_clear(level_clear),
      .o_flag(level_flag)
   );

   status_flag_cell u_overrun (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_set(overrun_set),
      .i_clear(status_read),
      .o_flag(overrun_flag)
   );

   status_flag_cell u_full (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_set(i_sample_write & full_now),
      .i_clear(status_read & ~full_now),
      .o_flag(full_flag)
   );

   status_flag_cell u_parity (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_set(parity_set),
      .i_clear(status_read),
      .o_flag(parity_flag)
   );

   // =========================================================================
   // Read port and output registers
   logic [7:0] status_byte, next_read_data;
   logic next_read_valid, next_first_axis;

   // Assembles the live status byte and the registered outputs.
   always_comb begin
      status_byte = 8'h00;
      status_byte[BIT_BUSY] = busy;
      status_byte[BIT_DONE] = done_flag;
      status_byte[BIT_WERR] = werr_flag;
      status_byte[BIT_READY] = (i_sample_count != '0);
      status_byte[BIT_LEVEL] = level_flag;
      status_byte[BIT_OVERRUN] = overrun_flag;
      status_byte[BIT_FULL] = full_flag;
      status_byte[BIT_PARITY] = parity_flag;
      next_read_data = status_read ? status_byte : o_read_data;
      next_read_valid = status_read;
      // Held until the next queue read, which must start a sample set.
      if (overrun_set) begin
         next_first_axis = 1'b1;
      end else if (i_queue_read_spi) begin
         next_first_axis = 1'b0;
      end else begin
         next_first_axis = o_first_axis_next;
      end
   end

   // Output registers.
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_read_data <= STATUS_RESET;
         o_read_valid <= 1'b0;
         o_interrupt_pin_zero <= 1'b1;
         o_write_alarm <= 1'b0;
         o_level_event <= 1'b0;
         o_realign_read_ptr <= 1'b0;
         o_first_axis_next <= 1'b0;
      end else begin
         o_read_data <= next_read_data;
         o_read_valid <= next_read_valid;
         o_interrupt_pin_zero <= (next_state == REFRESH_RUN);
         o_write_alarm <= werr_set;
         o_level_event <= level_flag;
         o_realign_read_ptr <= overrun_set;
         o_first_axis_next <= next_first_axis;
      end
   end

endmodule // status_flags_clear_on_read

`default_nettype wire

// ---- sim/status_flags_properties.sv ----
/* Checker for the status flag block.
   Bound onto status_flags_clear_on_read; sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module status_flags_properties
   import status_flags_pkg::*;
(
   input wire logic i_clock, // Clock.
   input wire logic i_rst, // Reset.
   input wire logic i_reg_read, // Read strobe.
   input wire logic i_reg_write, // Write strobe.
   input wire logic [7:0] i_reg_addr, // Address.
   input wire logic i_sample_write, // Sample write.
   input wire logic i_sample_overwrite, // Overwrite.
   input wire logic [1:0] i_queue_mode, // Queue mode.
   input wire logic [7:0] o_read_data, // Status byte.
   input wire logic o_read_valid, // Answer valid.
   input wire logic o_interrupt_pin_zero, // Busy pin.
   input wire logic o_write_alarm, // Alarm pulse.
   input wire logic o_level_event, // Level flag.
   input wire logic o_realign_read_ptr, // Realign pulse.
   input wire logic o_first_axis_next // First axis due.
);
   logic st_rd;
   logic ovw;
   // =====================================================================
   // Decoded causes: a status read, and an overwrite in stream or trigger.
   assign st_rd = i_reg_read && (i_reg_addr == STATUS_OFFSET);
   assign ovw = i_sample_overwrite && i_queue_mode[1];
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_rst);
   // =====================================================================
   // Register answer timing, hold of the byte, pin behaviour, the causes of the alarm and level outputs, and the realign and first-axis response to an overwrite.
   a_read_answer: assert property (st_rd |=> o_read_valid)
      else $error("status read not answered");
   a_stray_valid: assert property (!st_rd |=> !o_read_valid)
      else $error("valid without status read");
   a_data_hold: assert property (!st_rd |=> $stable(o_read_data))
      else $error("status byte changed without read");
   a_pin_release: assert property ($fell(i_rst) |-> o_interrupt_pin_zero)
      else $error("busy pin low after reset");
   a_busy_bit_pin: assert property (o_read_valid |->
      o_read_data[BIT_BUSY] == $past(o_interrupt_pin_zero))
      else $error("busy bit differs from busy pin");
   a_alarm_cause: assert property (o_write_alarm |-> $past(i_reg_write))
      else $error("alarm without write");
   a_level_cause: assert property ($rose(o_level_event) |-> $past(i_sample_write, 2))
      else $error("level rose without sample");
   a_realign_pulse: assert property (ovw |=> o_realign_read_ptr)
      else $error("no realign after overrun");
   a_first_axis: assert property (ovw |=> o_first_axis_next)
      else $error("first axis not flagged");
endmodule // status_flags_properties
bind status_flags_clear_on_read status_flags_properties u_status_flags_properties (
   .i_clock(i_clock), .i_rst(i_rst), .i_reg_read(i_reg_read), .i_reg_write(i_reg_write),
   .i_reg_addr(i_reg_addr), .i_sample_write(i_sample_write),
   .i_sample_overwrite(i_sample_overwrite), .i_queue_mode(i_queue_mode),
   .o_read_data(o_read_data), .o_read_valid(o_read_valid),
   .o_interrupt_pin_zero(o_interrupt_pin_zero), .o_write_alarm(o_write_alarm),
   .o_level_event(o_level_event), .o_realign_read_ptr(o_realign_read_ptr),
   .o_first_axis_next(o_first_axis_next));
`default_nettype wire

// ---- sim/host_register_model.sv ----
/* Host model: register strobes, chip select and queue reads.
   Assumes the bench calls its tasks on the device clock. */
`timescale 1ns/1ps
`default_nettype none
module host_register_model (
   input wire logic i_clock, // Clock.
   input wire logic [7:0] i_read_data, // Status byte.
   input wire logic i_read_valid, // Answer valid.
   output logic o_reg_read, // Read strobe.
   output logic o_reg_write, // Write strobe.
   output logic [7:0] o_reg_addr, // Address.
   output logic o_cs_n, // Chip select.
   output logic o_queue_read // Queue read pulse.
);
   // =====================================================================
   // Idle: deselected, strobes low.
   initial begin
      o_reg_read = 1'b0;
      o_reg_write = 1'b0;
      o_reg_addr = 8'h00;
      o_cs_n = 1'b1;
      o_queue_read = 1'b0;
   end
   // One access; a released address shows its inverse so it is never reused.
   task automatic access(input logic wr, input logic [7:0] a, output logic [7:0] b,
                         output logic v);
      @(posedge i_clock);
      o_reg_read <= !wr;
      o_reg_write <= wr;
      o_reg_addr <= a;
      @(posedge i_clock);
      o_reg_read <= 1'b0;
      o_reg_write <= 1'b0;
      o_reg_addr <= ~a;
      #1;
      b = i_read_data;
      v = i_read_valid;
   endtask
   // Queue read with chip select low, optionally kept low.
   task automatic queue_read(input logic keep);
      @(posedge i_clock);
      o_cs_n <= 1'b0;
      o_queue_read <= 1'b1;
      @(posedge i_clock);
      o_queue_read <= 1'b0;
      o_cs_n <= !keep;
      #1;
   endtask
   // Ends a frame left open.
   task automatic release_cs();
      @(posedge i_clock);
      o_cs_n <= 1'b1;
   endtask
endmodule // host_register_model
`default_nettype wire

// ---- sim/status_flags_clear_on_read_test.sv ----
/* Bench for the status flag block with a flag model.
   Assumes the host model drives strobes and chip select. */
`timescale 1ns/1ps
`default_nettype none
module status_flags_clear_on_read_test;
   import status_flags_pkg::*;
   localparam int RC = 20;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic sw = 1'b0, ow = 1'b0, three = 1'b0, pev = 1'b0, plv = 1'b0, sel = 1'b0;
   logic [1:0] qm = 2'h0;
   logic [8:0] cnt = 9'h000, thr = 9'h000;
   logic rr, rw, cs_n, qr, rv, pin, alarm, lev, realign, fax, v;
   logic [7:0] ra, rd, b;
   int fail_count = 0, checks = 0, cyc = 0, n, lim;
   bit mb, md, mw, ml, mo, mf, mp;
   status_flags_clear_on_read #(.REFRESH_COUNT(RC)) u_status_flags_clear_on_read (
      .i_clock(clk), .i_rst(rst), .i_reg_read(rr), .i_reg_write(rw), .i_reg_addr(ra),
      .i_cs_n(cs_n), .i_queue_read_spi(qr), .i_sample_write(sw), .i_sample_overwrite(ow),
      .i_sample_count(cnt), .i_level_threshold(thr), .i_queue_mode(qm),
      .i_three_channels(three), .i_parity_event(pev), .i_parity_live(plv),
      .i_latch_source_select(sel), .o_read_data(rd), .o_read_valid(rv),
      .o_interrupt_pin_zero(pin), .o_write_alarm(alarm), .o_level_event(lev),
      .o_realign_read_ptr(realign), .o_first_axis_next(fax));
   host_register_model u_host_register_model (
      .i_clock(clk), .i_read_data(rd), .i_read_valid(rv), .o_reg_read(rr),
      .o_reg_write(rw), .o_reg_addr(ra), .o_cs_n(cs_n), .o_queue_read(qr));
   // =====================================================================
   // Clock and a count of edges since reset release.
   initial begin
      forever #10 clk = ~clk;
   end
   always @(posedge clk) cyc <= rst ? 0 : cyc + 1;
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic complete_run();
      if (fail_count == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Status read against the model, which then clears done, write error, overrun and parity, recomputes full and clears level if chip select is high.
   task automatic status(input logic [7:0] mask);
      u_host_register_model.access(1'b0, STATUS_OFFSET, b, v);
      check("valid", {7'h00, v}, 8'h01);
      check("status", b & mask, {mb, md, mw, cnt != 0, ml, mo, mf, mp} & mask);
      md = 0;
      mw = 0;
      mo = 0;
      mp = 0;
      mf = (cnt >= lim);
      if (cs_n) ml = 0;
   endtask
   // One sample write; the model updates level, full and overrun.
   task automatic sample(input int c, input logic o);
      @(posedge clk);
      sw <= 1'b1;
      ow <= o;
      cnt <= 9'(c);
      @(posedge clk);
      sw <= 1'b0;
      ow <= 1'b0;
      #1;
      if (c > thr) ml = 1;
      if (c >= lim) mf = 1;
      if (o && qm[1]) mo = 1;
   endtask
   // =====================================================================
   // Main sequence.
   initial begin
      void'($urandom(39));
      thr <= 9'($urandom_range(8, 2));
      lim = QUEUE_DEPTH;
      mb = 1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      check("pin", {7'h00, pin}, 8'h01);
      status(8'hff);
      u_host_register_model.access(1'b1, 8'h30, b, v);
      check("alarm", {7'h00, alarm}, 8'h01);
      mw = 1;
      status(8'hff);
      status(8'hff);
      for (n = 0; pin && n < RC + 5; n++) begin
         @(posedge clk);
         #1;
      end
      check("refresh", {7'h00, cyc >= RC - 1 && cyc <= RC + 2}, 8'h01);
      if (pin) begin
         fail_count++;
         complete_run();
      end
      mb = 0;
      md = 1;
      u_host_register_model.access(1'b0, 8'h12, b, v);
      check("stray valid", {7'h00, v}, 8'h00);
      status(8'hff);
      status(8'hff);
      for (n = 1; n <= thr; n++) sample(n, 1'b0);
      status(8'hff);
      sample(thr + 1, 1'b0);
      @(posedge clk);
      #1;
      check("level out", {7'h00, lev}, 8'h01);
      u_host_register_model.queue_read(1'b1);
      status(8'hff);
      u_host_register_model.release_cs();
      repeat (6) @(posedge clk);
      #1;
      ml = 0;
      check("level clear", {7'h00, lev}, 8'h00);
      status(8'hff);
      for (n = 0; n < 4; n++) begin
         @(posedge clk);
         qm <= 2'(n);
         thr <= 9'h1ff;
         sample($urandom_range(300, 1), 1'b1);
         check("realign", {7'h00, realign}, {7'h00, qm[1]});
         check("axis", {7'h00, fax}, {7'h00, qm[1]});
         u_host_register_model.queue_read(1'b0);
         check("axis clear", {7'h00, fax}, 8'h00);
         status(qm == 2'h1 ? 8'hfb : 8'hff);
      end
      for (n = 0; n < 2; n++) begin
         @(posedge clk);
         three <= n[0];
         lim = n ? QUEUE_DEPTH_THREE_CH : QUEUE_DEPTH;
         sample(lim - 1, 1'b0);
         status(8'hff);
         sample(lim, 1'b0);
         status(8'hff);
         status(8'hff);
         @(posedge clk);
         cnt <= 9'h000;
         status(8'hff);
         status(8'hff);
      end
      for (n = 0; n < 3; n++) begin
         @(posedge clk);
         sel <= n > 0;
         pev <= n == 1;
         plv <= n != 1;
         @(posedge clk);
         pev <= 1'b0;
         plv <= 1'b0;
         mp = n < 2;
         status(8'hff);
      end
      @(posedge clk);
      sel <= 1'b0;
      fork
         u_host_register_model.access(1'b0, STATUS_OFFSET, b, v);
         begin
            @(posedge clk);
            plv <= 1'b1;
            @(posedge clk);
            plv <= 1'b0;
         end
      join
      check("read before event", b, 8'h00);
      mp = 1;
      status(8'hff);
      // Soft reset in mid-run: busy returns and every sticky flag is gone.
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      mb = 1;
      @(posedge clk);
      #1;
      check("pin again", {7'h00, pin}, 8'h01);
      check("data again", rd, STATUS_RESET);
      status(8'hff);
      complete_run();
   end
   // Hang guard.
   initial begin
      repeat (5000) @(posedge clk);
      fail_count++;
      complete_run();
   end
endmodule // status_flags_clear_on_read_test
`default_nettype wire
